/* File: hdl/swp_consts.vh */
// constants for the spi eeprom write-protect block: opcodes, status layout,
// guarded regions and timing counts; included by the top-level design file.
// assumes an 8192-byte array reached over a mode-0 serial link.
`ifndef SWP_CONSTS_VH
`define SWP_CONSTS_VH

// command opcodes
`define SWP_OP_ARRAY_WRITE 8'h02
`define SWP_OP_STATUS_READ 8'h05
`define SWP_OP_STATUS_WRITE 8'h01
`define SWP_OP_LATCH_SET 8'h06
`define SWP_OP_LATCH_CLEAR 8'h04

// status register bit positions
`define SWP_SR_ENABLE_BIT 7
`define SWP_SR_GUARD_HI_BIT 3
`define SWP_SR_GUARD_LO_BIT 2
`define SWP_SR_LATCH_BIT 1
`define SWP_SR_BUSY_BIT 0

// guard encodings and region starts (address bits 12:11)
`define SWP_GUARD_NONE 2'h0
`define SWP_GUARD_QUARTER 2'h1
`define SWP_GUARD_HALF 2'h2
`define SWP_GUARD_ALL 2'h3
`define SWP_ADDR_W 13
`define SWP_QUARTER_START 13'h1800
`define SWP_HALF_START 13'h1000

// frame byte counts
`define SWP_LEN_LATCH_CMD 3'h1
`define SWP_LEN_STATUS_WRITE 3'h2
`define SWP_LEN_ARRAY_WRITE 3'h4

// internal write cycle length in clk_sys cycles
`define SWP_WR_CYCLES 4000

// synchroniser reset value: {cs_n, sck, si, wp_n}
`define SWP_SYNC_RST 4'h9

`endif

/* File: hdl/swp_sync.v */
// two-flop synchroniser for a group of pin inputs.
// assumes the inputs are unrelated to clk_sys.
`timescale 1ns/100ps
module swp_sync #(
  parameter W       = 4,
  parameter RST_VAL = 4'h0
) (
  input  wire         clk_sys,  // system clock
  input  wire         sys_rst,  // async reset, active high
  input  wire [W-1:0] d_in,     // raw pin levels
  output wire [W-1:0] d_out     // synchronised levels
);

  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;

  // first stage feeds only the second stage
  always @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end
    else
    begin
      meta_q <= d_in;
      sync_q <= meta_q;
    end
  end

  assign d_out = sync_q;

endmodule

/* File: hdl/swp_wcycle.v */
// self-timed internal write cycle: busy from start until a done pulse.
// assumes start is a one-cycle pulse issued only while idle.
`timescale 1ns/100ps
module swp_wcycle #(
  parameter CYCLES = 4000,
  parameter CW     = 24
) (
  input  wire clk_sys,  // system clock
  input  wire sys_rst,  // async reset, active high
  input  wire start,    // one-cycle start pulse
  output reg  busy_q,   // cycle in progress
  output reg  done_q    // one-cycle end pulse
);

  // last count value, cut to the counter width on purpose
  localparam integer  LAST_I = CYCLES - 1;
  localparam [CW-1:0] LAST   = LAST_I[CW-1:0];

  reg [CW-1:0] cnt_q;

  // count the cycle out, then flag completion
  always @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      busy_q <= 1'b0;
      done_q <= 1'b0;
      cnt_q  <= {CW{1'b0}};
    end
    else
    begin
      done_q <= 1'b0;
      if (!busy_q && start)
      begin
        busy_q <= 1'b1;
        cnt_q  <= {CW{1'b0}};
      end
      else if (busy_q)
      begin
        if (cnt_q == LAST)
        begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end
        else
          cnt_q <= cnt_q + 1'b1;
      end
    end
  end

endmodule

/* File: hdl/swp_top.v */
// write-protect logic of a serial eeprom: decodes the latch, status and
// array-write commands; status writes are gated by latch and by the pin while the enable bit is set, array writes by latch and guard.
// assumes a mode-0 link sampled by clk_sys, far slower than clk_sys.
`timescale 1ns/100ps
`include "swp_consts.vh"
module swp_top #(
  parameter WR_CYCLES = `SWP_WR_CYCLES
) (
  input  wire        clk_sys,           // system clock
  input  wire        sys_rst,           // async reset, active high
  input  wire        spi_sck,           // serial clock pin
  input  wire        spi_cs_n,          // chip select pin, active low
  input  wire        spi_si,            // serial data in pin
  input  wire        wp_n,              // write-protect pin, active low
  input  wire        nv_enable_in,      // stored enable bit image
  input  wire [1:0]  nv_guard_in,       // stored guard bits image
  output reg         spi_so_q,          // serial data out level
  output reg         spi_so_oe_n_q,     // data out enable, low drives
  output reg         hw_protect_enable, // enable bit, status bit 7
  output reg         block_guard_hi,    // guard bit, status bit 3
  output reg         block_guard_lo,    // guard bit, status bit 2
  output reg         write_latch_flag,  // write latch, status bit 1
  output reg         write_busy_flag,   // write cycle busy, status bit 0
  output reg         hw_lock_q,         // hardware protection active
  output reg         active_q,          // left standby after select fall
  output reg         nv_commit_q,       // pulse: guard bits stored
  output reg         arr_commit_q,      // pulse: array write started
  output reg [12:0]  arr_addr_q         // start address of array write
);

  // synchronised pins
  wire [3:0] pin_s;
  wire       cs_s  = pin_s[3];
  wire       sck_s = pin_s[2];
  wire       si_s  = pin_s[1];
  wire       wp_s  = pin_s[0];

  swp_sync #(
    .W       (4),
    .RST_VAL (`SWP_SYNC_RST)
  ) u_sync (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .d_in    ({spi_cs_n, spi_sck, spi_si, wp_n}),
    .d_out   (pin_s)
  );

  reg        sck_prev_q;
  reg        cs_prev_q;
  reg        cs_seen_high_q;
  reg        nv_load_q;
  reg [7:0]  shift_in_q;
  reg [2:0]  bit_cnt_q;
  reg [2:0]  byte_cnt_q;
  reg [7:0]  opcode_q;
  reg [7:0]  sr_data_q;
  reg [15:0] addr_q;
  reg        rdsr_q;
  reg [7:0]  shift_out_q;
  reg        pend_status_q;
  reg        pend_enable_q;
  reg [1:0]  pend_guard_q;
  reg        start_q;
  reg        guarded;
  reg [1:0]  guard_d;

  wire cyc_busy;
  wire cyc_done;

  swp_wcycle #(
    .CYCLES (WR_CYCLES),
    .CW     (24)
  ) u_wcycle (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .start   (start_q),
    .busy_q  (cyc_busy),
    .done_q  (cyc_done)
  );

  // edges seen on the sampled link
  wire sck_rise  = sck_s & ~sck_prev_q;
  wire sck_fall  = ~sck_s & sck_prev_q;
  wire cs_rise   = cs_s & ~cs_prev_q;
  wire cs_fall   = ~cs_s & cs_prev_q;
  wire in_frame  = active_q & ~cs_s & ~cs_prev_q;
  wire bit_take  = in_frame & sck_rise;
  wire byte_done = bit_take & (bit_cnt_q == 3'h7);
  wire [7:0] byte_in = {shift_in_q[6:0], si_s};
  wire aligned   = (bit_cnt_q == 3'h0);
  wire frame_end = active_q & cs_rise;

  wire hw_lock = hw_protect_enable & ~wp_s;

  // status byte, unused positions read zero
  wire [7:0] status = {hw_protect_enable, 3'h0, block_guard_hi,
                       block_guard_lo, write_latch_flag, write_busy_flag};

  always @*
  begin
    guard_d = {block_guard_hi, block_guard_lo};
    case (guard_d)
      `SWP_GUARD_NONE:    guarded = 1'b0;
      `SWP_GUARD_QUARTER: guarded = (addr_q[12:0] >= `SWP_QUARTER_START);
      `SWP_GUARD_HALF:    guarded = (addr_q[12:0] >= `SWP_HALF_START);
      `SWP_GUARD_ALL:     guarded = 1'b1;
      default:            guarded = 1'b1;
    endcase
  end

  // edge history and power-up arming
  always @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sck_prev_q     <= 1'b0;
      cs_prev_q      <= 1'b1;
      cs_seen_high_q <= 1'b0;
      active_q       <= 1'b0;
      hw_lock_q      <= 1'b0;
    end
    else
    begin
      sck_prev_q <= sck_s;
      cs_prev_q  <= cs_s;
      hw_lock_q  <= hw_lock;
      if (cs_s)
        cs_seen_high_q <= 1'b1;
      if (cs_fall && cs_seen_high_q)
        active_q <= 1'b1;
    end
  end

  // input shifter and byte decode
  always @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      shift_in_q <= 8'h00;
      bit_cnt_q  <= 3'h0;
      byte_cnt_q <= 3'h0;
      opcode_q   <= 8'h00;
      sr_data_q  <= 8'h00;
      addr_q     <= 16'h0000;
    end
    else if (cs_s)
    begin
      bit_cnt_q  <= 3'h0;
      byte_cnt_q <= 3'h0;
    end
    else if (bit_take)
    begin
      shift_in_q <= byte_in;
      bit_cnt_q  <= bit_cnt_q + 3'h1;
      if (byte_done)
      begin
        if (byte_cnt_q != `SWP_LEN_ARRAY_WRITE)
          byte_cnt_q <= byte_cnt_q + 3'h1;
        case (byte_cnt_q)
          3'h0:
          begin
            opcode_q <= byte_in;
          end
          3'h1:
          begin
            sr_data_q     <= byte_in;
            addr_q[15:8]  <= byte_in;
          end
          3'h2:
          begin
            addr_q[7:0] <= byte_in;
          end
          default:
          begin
            addr_q <= addr_q;
          end
        endcase
      end
    end
  end

  // status read-out, shifted on falling clock
  always @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      spi_so_q      <= 1'b0;
      spi_so_oe_n_q <= 1'b1;
      rdsr_q        <= 1'b0;
      shift_out_q   <= 8'h00;
    end
    else if (cs_s || !active_q)
    begin
      spi_so_oe_n_q <= 1'b1;
      rdsr_q        <= 1'b0;
    end
    else
    begin
      if (byte_done && (rdsr_q || (byte_cnt_q == 3'h0 &&
          byte_in == `SWP_OP_STATUS_READ)))
      begin
        rdsr_q      <= 1'b1;
        shift_out_q <= status;
      end
      else if (in_frame && sck_fall && rdsr_q)
      begin
        spi_so_q      <= shift_out_q[7];
        spi_so_oe_n_q <= 1'b0;
        shift_out_q   <= {shift_out_q[6:0], 1'b0};
      end
    end
  end

  // command execution at the end of a frame
  always @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      write_latch_flag  <= 1'b0;
      write_busy_flag   <= 1'b0;
      hw_protect_enable <= 1'b0;
      block_guard_hi    <= 1'b0;
      block_guard_lo    <= 1'b0;
      nv_load_q         <= 1'b1;
      nv_commit_q       <= 1'b0;
      arr_commit_q      <= 1'b0;
      arr_addr_q        <= 13'h0000;
      pend_status_q     <= 1'b0;
      pend_enable_q     <= 1'b0;
      pend_guard_q      <= 2'h0;
      start_q           <= 1'b0;
    end
    else
    begin
      start_q         <= 1'b0;
      arr_commit_q    <= 1'b0;
      nv_commit_q     <= 1'b0;
      write_busy_flag <= cyc_busy | start_q;
      if (nv_load_q)
      begin
        nv_load_q         <= 1'b0;
        hw_protect_enable <= nv_enable_in;
        block_guard_hi    <= nv_guard_in[1];
        block_guard_lo    <= nv_guard_in[0];
      end
      else if (cyc_done)
      begin
        write_latch_flag <= 1'b0;
        pend_status_q    <= 1'b0;
        if (pend_status_q)
        begin
          hw_protect_enable <= pend_enable_q;
          block_guard_hi    <= pend_guard_q[1];
          block_guard_lo    <= pend_guard_q[0];
          nv_commit_q       <= 1'b1;
        end
      end
      else if (frame_end && aligned && !write_busy_flag)
      begin
        case (opcode_q)
          `SWP_OP_LATCH_SET:
          begin
            if (byte_cnt_q == `SWP_LEN_LATCH_CMD)
              write_latch_flag <= 1'b1;
          end
          `SWP_OP_LATCH_CLEAR:
          begin
            if (byte_cnt_q == `SWP_LEN_LATCH_CMD)
              write_latch_flag <= 1'b0;
          end
          `SWP_OP_STATUS_WRITE:
          begin
            if (byte_cnt_q == `SWP_LEN_STATUS_WRITE &&
                write_latch_flag && !hw_lock)
            begin
              start_q       <= 1'b1;
              pend_status_q <= 1'b1;
              pend_enable_q <= sr_data_q[`SWP_SR_ENABLE_BIT];
              pend_guard_q  <= {sr_data_q[`SWP_SR_GUARD_HI_BIT],
                                sr_data_q[`SWP_SR_GUARD_LO_BIT]};
            end
          end
          `SWP_OP_ARRAY_WRITE:
          begin
            if (byte_cnt_q == `SWP_LEN_ARRAY_WRITE &&
                write_latch_flag && !guarded)
            begin
              start_q      <= 1'b1;
              arr_commit_q <= 1'b1;
              arr_addr_q   <= addr_q[12:0];
            end
          end
          default:
          begin
            start_q <= 1'b0;
          end
        endcase
      end
    end
  end

endmodule

/* File: sim/swp_assertions.sv */
// checker: protection relations seen at the top-level ports.
// assumes binding into swp_top; one clock domain.
`timescale 1ns/100ps
module swp_checker #(
  parameter WR_CYCLES = 4000
) (
  input wire        clk_sys,           // clock
  input wire        sys_rst,           // reset
  input wire        spi_cs_n,          // select
  input wire        wp_n,              // protect pin
  input wire        spi_so_oe_n_q,     // out enable
  input wire        hw_protect_enable, // enable bit
  input wire        block_guard_hi,    // guard hi
  input wire        block_guard_lo,    // guard lo
  input wire        write_latch_flag,  // latch
  input wire        write_busy_flag,   // busy
  input wire        hw_lock_q,         // lock
  input wire        active_q,          // awake
  input wire        nv_commit_q,       // status stored
  input wire        arr_commit_q,      // array write start
  input wire [12:0] arr_addr_q         // array address
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // guard pair as one field
  wire [1:0] grd = {block_guard_hi, block_guard_lo};
  // cycles the busy flag has stood so far
  logic [31:0] busy_cnt;
  always @(posedge clk_sys or posedge sys_rst)
    if (sys_rst)
      busy_cnt <= 32'h0;
    else if (write_busy_flag)
      busy_cnt <= busy_cnt + 32'h1;
    else
      busy_cnt <= 32'h0;

  property p_latch_arr; arr_commit_q |-> write_latch_flag; endproperty
  a_latch_arr: assert property (p_latch_arr) else $error("array write without latch");
  property p_guard;
    arr_commit_q |-> grd == 2'h0 || (grd == 2'h1 && arr_addr_q < 13'h1800)
      || (grd == 2'h2 && arr_addr_q < 13'h1000);
  endproperty
  a_guard: assert property (p_guard) else $error("guarded address written");
  property p_lock_on; (hw_protect_enable && !wp_n) [*5] |-> hw_lock_q; endproperty
  a_lock_on: assert property (p_lock_on) else $error("lock not entered");
  property p_lock_off; (!hw_protect_enable || wp_n) [*5] |-> !hw_lock_q; endproperty
  a_lock_off: assert property (p_lock_off) else $error("lock without cause");
  property p_lock_blk; nv_commit_q |-> !$past(hw_lock_q); endproperty
  a_lock_blk: assert property (p_lock_blk) else $error("status stored under lock");
  property p_latch_clr; $fell(write_busy_flag) |-> ##[0:1] !write_latch_flag; endproperty
  a_latch_clr: assert property (p_latch_clr) else $error("latch kept after write");
  property p_busy_ign; arr_commit_q |-> !$past(write_busy_flag); endproperty
  a_busy_ign: assert property (p_busy_ign) else $error("write taken while busy");
  property p_busy_end; busy_cnt <= WR_CYCLES + 1; endproperty
  a_busy_end: assert property (p_busy_end) else $error("busy never ends");
  property p_busy_len; $fell(write_busy_flag) |-> busy_cnt == WR_CYCLES + 1; endproperty
  a_busy_len: assert property (p_busy_len) else $error("busy length wrong");
  property p_float; spi_cs_n [*6] |-> spi_so_oe_n_q; endproperty
  a_float: assert property (p_float) else $error("output driven while idle");
  property p_wake; $rose(active_q) |-> !spi_cs_n; endproperty
  a_wake: assert property (p_wake) else $error("woke without select");

  c_arr: cover property (arr_commit_q);
  c_nv: cover property (nv_commit_q);
  c_lock: cover property (hw_lock_q && write_latch_flag);
  c_read: cover property (!spi_so_oe_n_q && write_busy_flag);
endmodule

bind swp_top swp_checker #(.WR_CYCLES(WR_CYCLES)) u_chk (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .spi_cs_n(spi_cs_n), .wp_n(wp_n),
  .spi_so_oe_n_q(spi_so_oe_n_q), .hw_protect_enable(hw_protect_enable),
  .block_guard_hi(block_guard_hi), .block_guard_lo(block_guard_lo),
  .write_latch_flag(write_latch_flag), .write_busy_flag(write_busy_flag),
  .hw_lock_q(hw_lock_q), .active_q(active_q), .nv_commit_q(nv_commit_q),
  .arr_commit_q(arr_commit_q), .arr_addr_q(arr_addr_q)
);

/* File: sim/swp_host.sv */
// host serial master model: mode-0 frames, msb first.
// assumes select-high gaps long enough for the device synchronisers.
`timescale 1ns/100ps
module swp_host (
  input  wire spi_so,   // data from device, pulled up when released
  output reg  spi_sck,  // serial clock, low between frames
  output reg  spi_cs_n, // select, active low
  output reg  spi_si    // data to device
);
  // bits seen on data out, latest at bit 0
  reg [31:0] rx;
  // idle levels at time zero
  initial
  begin
    spi_sck = 1'b0;
    spi_cs_n = 1'b1;
    spi_si = 1'b0;
  end
  // one frame of nb bytes, the last cut bits left off
  task send(input [31:0] v, input integer nb, input integer cut);
    integer i;
    begin
      spi_cs_n = 1'b0;
      for (i = 8 * nb - 1; i >= cut; i = i - 1)
      begin
        spi_si = v[i];
        #62.5 spi_sck = 1'b1;
        rx = {rx[30:0], spi_so};
        #62.5 spi_sck = 1'b0;
      end
      #62.5 spi_cs_n = 1'b1;
      spi_si = ~spi_si;
      #100;
    end
  endtask
endmodule

/* File: sim/swp_top_tb.sv */
// bench for the write-protect block: host frames, pin levels, checks.
// assumes swp_host as serial master and a shortened write cycle.
`timescale 1ns/100ps
module swp_top_tb;
  reg         clk_sys, sys_rst, wp_n, nv_enable_in;
  reg  [1:0]  nv_guard_in;
  wire        spi_sck, spi_cs_n, spi_si, spi_so_q, spi_so_oe_n_q, hw_protect_enable;
  wire        block_guard_hi, block_guard_lo, write_latch_flag, write_busy_flag;
  wire        hw_lock_q, active_q, nv_commit_q, arr_commit_q;
  wire [12:0] arr_addr_q;
  reg  [12:0] last_addr, addr;
  integer     err_count, samples_checked, commits, n, g, a;

  // system clock
  initial
  begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  swp_host HOST (.spi_so(spi_so_oe_n_q ? 1'b1 : spi_so_q), .spi_sck(spi_sck),
    .spi_cs_n(spi_cs_n), .spi_si(spi_si));
  swp_top #(.WR_CYCLES(1000)) DUT (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .spi_sck(spi_sck), .spi_cs_n(spi_cs_n),
    .spi_si(spi_si), .wp_n(wp_n), .nv_enable_in(nv_enable_in), .nv_guard_in(nv_guard_in),
    .spi_so_q(spi_so_q), .spi_so_oe_n_q(spi_so_oe_n_q), .hw_protect_enable(hw_protect_enable),
    .block_guard_hi(block_guard_hi), .block_guard_lo(block_guard_lo),
    .write_latch_flag(write_latch_flag), .write_busy_flag(write_busy_flag),
    .hw_lock_q(hw_lock_q), .active_q(active_q), .nv_commit_q(nv_commit_q),
    .arr_commit_q(arr_commit_q), .arr_addr_q(arr_addr_q)
  );

  // count accepted array writes
  always @(posedge clk_sys)
    if (arr_commit_q === 1'b1)
    begin
      commits = commits + 1;
      last_addr = arr_addr_q;
    end

  task chk_bit(input got, input exp);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp)
      begin
        err_count = err_count + 1;
        $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task chk_addr(input [12:0] got, input [12:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp)
      begin
        err_count = err_count + 1;
        $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  // one frame, then time for the select rise to act
  task frame(input [31:0] v, input integer nb, input integer cut);
    begin
      HOST.send(v, nb, cut);
      repeat (8) @(negedge clk_sys);
    end
  endtask
  task wait_idle;
    integer i;
    begin
      i = 0;
      while (write_busy_flag !== 1'b0 && i < 2000)
      begin
        @(negedge clk_sys);
        i = i + 1;
      end
      chk_bit(write_busy_flag, 1'b0);
    end
  endtask
  // latch set, array write, acceptance compared
  task try_write(input [12:0] ad, input ok);
    begin
      n = commits;
      frame(32'h06, 1, 0);
      frame({8'h02, 3'h0, ad, 8'hA5}, 4, 0);
      wait_idle;
      chk_bit(commits != n, ok);
      if (ok)
        chk_addr(last_addr, ad);
    end
  endtask
  task set_status(input [7:0] d);
    begin
      frame(32'h06, 1, 0);
      frame({16'h0, 8'h01, d}, 2, 0);
    end
  endtask
  task chk_byte(input [7:0] got, input [7:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp)
      begin
        err_count = err_count + 1;
        $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  // status read frame, byte caught by the host compared
  task rd_status(input [7:0] exp);
    begin
      frame(32'h0500, 2, 0);
      chk_byte(HOST.rx[7:0], exp);
    end
  endtask
  task report_and_stop;
    begin
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask

  // watchdog against a hung sequence
  initial
  begin
    #700000;
    err_count = err_count + 1;
    report_and_stop;
  end

  // main sequence
  initial
  begin
    err_count = 0;
    samples_checked = 0;
    commits = 0;
    last_addr = 13'h0;
    addr = 13'h0;
    sys_rst = 1'b1;
    wp_n = 1'b1;
    nv_enable_in = 1'b1;
    nv_guard_in = 2'h1;
    repeat (6) @(posedge clk_sys);
    sys_rst <= 1'b0;
    repeat (8) @(negedge clk_sys);
    chk_bit(write_latch_flag, 1'b0);
    chk_bit(spi_so_oe_n_q, 1'b1);
    chk_bit(active_q, 1'b0);
    chk_bit(hw_protect_enable, 1'b1);
    chk_bit(block_guard_lo, 1'b1);
    $display("power_up done");
    frame(32'h010C, 2, 0);
    wait_idle;
    chk_bit(active_q, 1'b1);
    chk_bit(block_guard_hi, 1'b0);
    frame(32'h06, 1, 0);
    chk_bit(write_latch_flag, 1'b1);
    frame(32'h04, 1, 0);
    chk_bit(write_latch_flag, 1'b0);
    frame(32'h06, 1, 1);
    chk_bit(write_latch_flag, 1'b0);
    frame(32'h06, 1, 0);
    frame(32'h010C, 2, 1);
    wait_idle;
    chk_bit(block_guard_hi, 1'b0);
    $display("latch done");
    @(posedge clk_sys) wp_n <= 1'b0;
    repeat (8) @(negedge clk_sys);
    chk_bit(hw_lock_q, 1'b1);
    set_status(8'h0C);
    wait_idle;
    chk_bit(block_guard_hi, 1'b0);
    try_write(13'h17FF, 1'b1);
    chk_bit(write_latch_flag, 1'b0);
    try_write(13'h1800, 1'b0);
    $display("hw_lock done");
    @(posedge clk_sys) wp_n <= 1'b1;
    repeat (8) @(negedge clk_sys);
    chk_bit(hw_lock_q, 1'b0);
    set_status(8'h0F);
    rd_status(8'h87);
    n = commits;
    frame({8'h02, 24'h0}, 4, 0);
    wait_idle;
    chk_bit(commits != n, 1'b0);
    chk_bit(hw_protect_enable, 1'b0);
    chk_bit(block_guard_hi, 1'b1);
    chk_bit(write_latch_flag, 1'b0);
    rd_status(8'h0C);
    $display("status done");
    @(posedge clk_sys) wp_n <= 1'b0;
    repeat (8) @(negedge clk_sys);
    for (g = 0; g < 4; g = g + 1)
    begin
      set_status({4'h0, g[1:0], 2'h0});
      wait_idle;
      chk_bit(hw_lock_q, 1'b0);
      chk_bit(block_guard_hi, g[1]);
      for (a = 0; a < 4; a = a + 1)
      begin
        addr = {a[1:0], 11'h0};
        try_write(addr, g == 0 || (g == 1 && addr < 13'h1800) || (g == 2 && addr < 13'h1000));
      end
    end
    $display("guard done");
    report_and_stop;
  end
endmodule
